/* src/flc_ctrl.v */
`timescale 1ns/1ps
`include "flc_defines.vh"

// Contract
// - Array erases in 1-KB blocks, setting every bit of the block to one.
// - Program acts on one 32-bit word and only clears bits.
// - Protection applies per 2-KB unit, each with its own policy.
// - Operation timing uses software cycles-per-microsecond count, encoded MHz minus one.
// - Program-enable one permits program and erase; zero keeps block unchanged.
// - Read-enable zero allows only instruction fetches; data reads refused.
// - Policy pairs: 00 execute-only, 01 read-only, 10 write-no-read, 11 open.
// - Data read of a read-protected block is blocked with a bus fault.
// - Program or erase on protected block refused; masked access interrupt raised.
// - All implemented protection bits start at one.
// - Protection bits only clear; uncommitted ones return to one at power-on.
// - Commit through the control register stores protection values nonvolatile.
// - Protection held in two pairs of 32-bit registers, one bit per unit.
// - Fetches from flash are held off while an operation runs.
// - Writing one to the clear register clears raw and masked flags.
module flc_ctrl (
    input  wire                 clk_i,
    input  wire                 reset_i,
    // Register port
    input  wire [7:0]           reg_addr_i,
    input  wire [31:0]          reg_wdata_i,
    input  wire                 reg_we_i,
    input  wire                 reg_re_i,
    output reg  [31:0]          reg_rdata_o,
    // Processor flash accesses
    input  wire                 acc_valid_i,
    input  wire                 acc_fetch_i,
    input  wire [`FLC_AW-1:0]   acc_addr_i,
    output wire                 acc_ready_o,
    output wire                 acc_fault_o,
    // Flash array
    input  wire [31:0]          arr_rdata_i,
    output wire [`FLC_AW-1:0]   arr_addr_o,
    output reg  [31:0]          arr_wdata_o,
    output reg                  arr_prog_o,
    output reg                  arr_erase_o,
    output reg                  arr_merase_o,
    // Nonvolatile protection store
    input  wire [`FLC_NBLK-1:0] nv_pe_i,
    input  wire [`FLC_NBLK-1:0] nv_re_i,
    output reg                  nv_commit_o,
    output wire [`FLC_NBLK-1:0] nv_pe_o,
    output wire [`FLC_NBLK-1:0] nv_re_o,
    // Interrupt
    output wire                 irq_o
);

    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg  [1:0]           state_r;
    reg  [`FLC_AW-1:0]   addr_r;
    reg  [`FLC_AW-1:0]   arr_addr_r;
    reg  [31:0]          data_r;
    reg  [7:0]           usec_r;
    reg  [2:0]           op_r;
    reg  [1:0]           raw_r;
    reg  [1:0]           mask_r;
    reg  [`FLC_NBLK-1:0] pe_r;
    reg  [`FLC_NBLK-1:0] re_r;
    reg  [15:0]          dur_nxt;
    wire                 tmr_busy;
    wire                 tmr_done;

    // ==========================================================
    // Decode of register writes
    wire wr_addr  = reg_we_i && (reg_addr_i == `FLC_OFS_ADDR);
    wire wr_data  = reg_we_i && (reg_addr_i == `FLC_OFS_DATA);
    wire wr_ctrl  = reg_we_i && (reg_addr_i == `FLC_OFS_CTRL) &&
                    (reg_wdata_i[31:`FLC_KEY_LSB] == `FLC_KEY_VAL);
    wire wr_mask  = reg_we_i && (reg_addr_i == `FLC_OFS_MASK);
    wire wr_clear = reg_we_i && (reg_addr_i == `FLC_OFS_CLEAR);
    wire wr_usec  = reg_we_i && (reg_addr_i == `FLC_OFS_USEC);
    wire wr_pe0   = reg_we_i && (reg_addr_i == `FLC_OFS_PE0);
    wire wr_pe1   = reg_we_i && (reg_addr_i == `FLC_OFS_PE1);
    wire wr_re0   = reg_we_i && (reg_addr_i == `FLC_OFS_RE0);
    wire wr_re1   = reg_we_i && (reg_addr_i == `FLC_OFS_RE1);

    wire idle     = (state_r == ST_IDLE);
    wire req_prog = wr_ctrl && reg_wdata_i[`FLC_CTRL_WRITE];
    wire req_ers  = wr_ctrl && !reg_wdata_i[`FLC_CTRL_WRITE] && reg_wdata_i[`FLC_CTRL_ERASE];
    wire req_mers = wr_ctrl && !reg_wdata_i[`FLC_CTRL_WRITE] && !reg_wdata_i[`FLC_CTRL_ERASE] &&
                    reg_wdata_i[`FLC_CTRL_MERASE];
    wire req_any  = req_prog || req_ers || req_mers;

    // ==========================================================
    // Protection lookup per 2-KB unit
    wire [5:0] op_blk  = addr_r[`FLC_AW-1:`FLC_PBLK_LSB];
    wire [5:0] acc_blk = acc_addr_i[`FLC_AW-1:`FLC_PBLK_LSB];
    wire op_in     = (op_blk < `FLC_NBLK);
    wire acc_in    = (acc_blk < `FLC_NBLK);
    wire op_pe_ok  = op_in && pe_r[op_blk];
    // Mass erase would wipe program-protected units, so any cleared program-enable bit refuses it
    wire all_pe_ok = &pe_r;
    wire op_ok     = req_mers ? all_pe_ok : op_pe_ok;
    wire acc_re_ok = acc_in && re_r[acc_blk];
    wire refuse    = idle && req_any && !op_ok;

    // ==========================================================
    // Processor side: stall during operations, fault protected data reads
    assign acc_ready_o = idle;
    assign acc_fault_o = acc_valid_i && idle && !acc_fetch_i && !acc_re_ok;

    assign arr_addr_o = arr_addr_r;

    always @* begin
        if (req_prog) begin
            dur_nxt = `FLC_PROG_US;
        end else if (req_ers) begin
            dur_nxt = `FLC_ERASE_US;
        end else begin
            dur_nxt = `FLC_MERASE_US;
        end
    end

    flc_us_timer u_timer (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .start_i  (idle && req_any && op_ok),
        .reload_i (usec_r),
        .dur_i    (dur_nxt),
        .busy_o   (tmr_busy),
        .done_o   (tmr_done)
    );

    // ==========================================================
    // Operation sequencer
    always @(posedge clk_i) begin
        if (reset_i) begin
            state_r      <= ST_IDLE;
            op_r         <= 3'b000;
            arr_prog_o   <= 1'b0;
            arr_erase_o  <= 1'b0;
            arr_merase_o <= 1'b0;
            arr_wdata_o  <= 32'h0000_0000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (req_any && op_ok) begin
                        op_r         <= {req_mers, req_ers, req_prog};
                        arr_prog_o   <= req_prog;
                        arr_erase_o  <= req_ers;
                        arr_merase_o <= req_mers;
                        // Array can only pull bits low, so merge with old word
                        arr_wdata_o  <= arr_rdata_i & data_r;
                        state_r      <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (tmr_done || !tmr_busy) begin
                        op_r         <= 3'b000;
                        arr_prog_o   <= 1'b0;
                        arr_erase_o  <= 1'b0;
                        arr_merase_o <= 1'b0;
                        state_r      <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Array address register
    // Word address while idle so the program merge reads the target word,
    // block base only for the length of an erase
    always @(posedge clk_i) begin
        if (reset_i) begin
            arr_addr_r <= {`FLC_AW{1'b0}};
        end else if (idle && wr_addr) begin
            arr_addr_r <= {reg_wdata_i[`FLC_AW-1:2], 2'b00};
        end else if (idle && (req_ers || req_mers) && op_ok) begin
            arr_addr_r <= {addr_r[`FLC_AW-1:`FLC_EBLK_LSB], {`FLC_EBLK_LSB{1'b0}}};
        end else if (!idle && tmr_done) begin
            arr_addr_r <= {addr_r[`FLC_AW-1:2], 2'b00};
        end
    end

    // ==========================================================
    // Software registers
    always @(posedge clk_i) begin
        if (reset_i) begin
            addr_r      <= {`FLC_AW{1'b0}};
            data_r      <= 32'h0000_0000;
            usec_r      <= `FLC_USEC_RST;
            mask_r      <= 2'b00;
            nv_commit_o <= 1'b0;
        end else begin
            nv_commit_o <= wr_ctrl && reg_wdata_i[`FLC_CTRL_COMMIT] && idle;
            if (wr_addr && idle) begin
                addr_r <= reg_wdata_i[`FLC_AW-1:0];
            end
            if (wr_data && idle) begin
                data_r <= reg_wdata_i;
            end
            if (wr_usec) begin
                usec_r <= reg_wdata_i[7:0];
            end
            if (wr_mask) begin
                mask_r <= reg_wdata_i[1:0];
            end
        end
    end

    // Sticky flags: a new event in the clearing cycle survives
    always @(posedge clk_i) begin
        if (reset_i) begin
            raw_r <= 2'b00;
        end else begin
            raw_r[`FLC_IRQ_ACCESS] <= (raw_r[`FLC_IRQ_ACCESS] &&
                                      !(wr_clear && reg_wdata_i[`FLC_IRQ_ACCESS])) || refuse;
            raw_r[`FLC_IRQ_DONE]   <= (raw_r[`FLC_IRQ_DONE] &&
                                      !(wr_clear && reg_wdata_i[`FLC_IRQ_DONE])) || tmr_done;
        end
    end

    assign irq_o = |(raw_r & mask_r);

    // ==========================================================
    // Protection bits: clear only, reloaded from store at power-on
    genvar g;
    generate
        for (g = 0; g < `FLC_NBLK; g = g + 1) begin : g_prot
            wire pe_clr = (g < 32) ? (wr_pe0 && !reg_wdata_i[g % 32]) : (wr_pe1 && !reg_wdata_i[g % 32]);
            wire re_clr = (g < 32) ? (wr_re0 && !reg_wdata_i[g % 32]) : (wr_re1 && !reg_wdata_i[g % 32]);
            always @(posedge clk_i) begin
                if (reset_i) begin
                    pe_r[g] <= nv_pe_i[g];
                    re_r[g] <= nv_re_i[g];
                end else begin
                    pe_r[g] <= pe_r[g] && !pe_clr;
                    re_r[g] <= re_r[g] && !re_clr;
                end
            end
        end
    endgenerate

    assign nv_pe_o = pe_r;
    assign nv_re_o = re_r;

    // ==========================================================
    // Read port, data one cycle after the strobe
    always @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `FLC_OFS_ADDR:  reg_rdata_o <= {{(32-`FLC_AW){1'b0}}, addr_r};
                `FLC_OFS_DATA:  reg_rdata_o <= data_r;
                `FLC_OFS_CTRL:  reg_rdata_o <= {29'h0000_0000, op_r};
                `FLC_OFS_RAW:   reg_rdata_o <= {30'h0000_0000, raw_r};
                `FLC_OFS_MASK:  reg_rdata_o <= {30'h0000_0000, mask_r};
                `FLC_OFS_MSTAT: reg_rdata_o <= {30'h0000_0000, raw_r & mask_r};
                `FLC_OFS_USEC:  reg_rdata_o <= {24'h00_0000, usec_r};
                `FLC_OFS_PE0:   reg_rdata_o <= pe_r[31:0];
                `FLC_OFS_PE1:   reg_rdata_o <= {16'h0000, pe_r[`FLC_NBLK-1:32]};
                `FLC_OFS_RE0:   reg_rdata_o <= re_r[31:0];
                `FLC_OFS_RE1:   reg_rdata_o <= {16'h0000, re_r[`FLC_NBLK-1:32]};
                default:        reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule

/* src/flc_defines.vh */
`ifndef FLC_DEFINES_VH
`define FLC_DEFINES_VH

// ==========================================================
// Register byte offsets
`define FLC_OFS_ADDR      8'h00
`define FLC_OFS_DATA      8'h04
`define FLC_OFS_CTRL      8'h08
`define FLC_OFS_RAW       8'h0c
`define FLC_OFS_MASK      8'h10
`define FLC_OFS_MSTAT     8'h14
`define FLC_OFS_CLEAR     8'h18
`define FLC_OFS_USEC      8'h1c
`define FLC_OFS_PE0       8'h20
`define FLC_OFS_PE1       8'h24
`define FLC_OFS_RE0       8'h28
`define FLC_OFS_RE1       8'h2c

// ==========================================================
// Control register fields
`define FLC_KEY_LSB       16
`define FLC_KEY_VAL       16'ha442
`define FLC_CTRL_WRITE    0
`define FLC_CTRL_ERASE    1
`define FLC_CTRL_MERASE   2
`define FLC_CTRL_COMMIT   3

// Interrupt status fields
`define FLC_IRQ_ACCESS    0
`define FLC_IRQ_DONE      1

// ==========================================================
// Array geometry
`define FLC_AW            17
`define FLC_NBLK          48
`define FLC_PBLK_LSB      11
`define FLC_EBLK_LSB      10

// ==========================================================
// Reset values and timing
`define FLC_USEC_RST      8'h31
`define FLC_PROG_US       16'h0014
`define FLC_ERASE_US      16'h4e20
`define FLC_MERASE_US     16'hc350

`endif

/* src/flc_us_timer.v */
`timescale 1ns/1ps
`include "flc_defines.vh"

module flc_us_timer (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        start_i,
    input  wire [7:0]  reload_i,
    input  wire [15:0] dur_i,
    output wire        busy_o,
    output reg         done_o
);

    reg [7:0]  pre_r;
    reg [15:0] us_r;
    reg        run_r;

    assign busy_o = run_r;

    // ==========================================================
    // Microsecond prescaler, reloaded from the software count
    always @(posedge clk_i) begin
        if (reset_i) begin
            pre_r  <= 8'h00;
            us_r   <= 16'h0000;
            run_r  <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !run_r) begin
                pre_r <= reload_i;
                us_r  <= dur_i;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (pre_r != 8'h00) begin
                    pre_r <= pre_r - 8'h01;
                end else begin
                    // Reload value is MHz minus one, so reload+1 cycles per us
                    pre_r <= reload_i;
                    if (us_r <= 16'h0001) begin
                        run_r  <= 1'b0;
                        done_o <= 1'b1;
                    end else begin
                        us_r <= us_r - 16'h0001;
                    end
                end
            end
        end
    end

endmodule

/* verification/flc_ctrl_assertions.sv */
`timescale 1ns/1ps
`include "flc_defines.vh"
// ==========================================
// Port checker
module flc_ctrl_assertions (
    input wire        clk_i,
    input wire        reset_i,
    input wire        acc_valid_i,
    input wire        acc_fetch_i,
    input wire [16:0] acc_addr_i,
    input wire        acc_ready_o,
    input wire        acc_fault_o,
    input wire [31:0] arr_rdata_i,
    input wire [16:0] arr_addr_o,
    input wire [31:0] arr_wdata_o,
    input wire        arr_prog_o,
    input wire        arr_erase_o,
    input wire        arr_merase_o,
    input wire        nv_commit_o,
    input wire [47:0] nv_pe_o,
    input wire [47:0] nv_re_o
);
    wire busy_w = arr_prog_o | arr_erase_o | arr_merase_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_fault_cause: assert property (acc_fault_o |-> acc_valid_i && !acc_fetch_i && acc_ready_o)
        else $error("fault without data read");
    a_fetch_clean: assert property (acc_valid_i && acc_fetch_i |-> !acc_fault_o)
        else $error("fetch faulted");
    a_hold_fetch: assert property (busy_w |-> !acc_ready_o)
        else $error("ready during operation");
    a_one_op: assert property ($onehot0({arr_prog_o, arr_erase_o, arr_merase_o}))
        else $error("overlapping operations");
    a_commit_pulse: assert property (nv_commit_o |=> !nv_commit_o)
        else $error("commit longer than one cycle");
    // First edge after reset compares against reset load, so skip it
    a_pe_clear_only: assert property (!$past(reset_i) |-> (nv_pe_o & ~$past(nv_pe_o)) == 48'h0)
        else $error("program enable bit set");
    a_re_clear_only: assert property (!$past(reset_i) |-> (nv_re_o & ~$past(nv_re_o)) == 48'h0)
        else $error("read enable bit set");
    a_prog_clears: assert property ($rose(arr_prog_o) |-> (arr_wdata_o & ~arr_rdata_i) == 32'h0)
        else $error("program sets a bit");
    a_erase_align: assert property (arr_erase_o |-> arr_addr_o[9:0] == 10'h0)
        else $error("erase not block aligned");
    a_range_fault: assert property (acc_valid_i && !acc_fetch_i && acc_ready_o
        && acc_addr_i >= 17'h18000 |-> acc_fault_o)
        else $error("out of range read passed");
    cover property ($rose(arr_prog_o));
    cover property ($rose(arr_erase_o));
    cover property (acc_fault_o);
    cover property (nv_commit_o);
endmodule

/* verification/flc_ctrl_tb.sv */
`timescale 1ns/1ps
`include "flc_defines.vh"
module flc_ctrl_tb;
    logic        clk_i = 0, reset_i = 1, reg_we_i = 0, reg_re_i = 0, acc_valid_i = 0, acc_fetch_i = 0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [16:0] acc_addr_i = 17'h0;
    wire  [31:0] reg_rdata_o, arr_rdata_i, arr_wdata_o;
    wire  [16:0] arr_addr_o;
    wire  [47:0] nv_pe_i, nv_re_i, nv_pe_o, nv_re_o;
    wire         acc_ready_o, acc_fault_o, arr_prog_o, arr_erase_o, arr_merase_o, nv_commit_o, irq_o;
    int          err_total = 0, samples_checked = 0, n;
    always #5 clk_i = ~clk_i;
    flc_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .acc_valid_i(acc_valid_i),
        .acc_fetch_i(acc_fetch_i), .acc_addr_i(acc_addr_i), .acc_ready_o(acc_ready_o),
        .acc_fault_o(acc_fault_o), .arr_rdata_i(arr_rdata_i), .arr_addr_o(arr_addr_o),
        .arr_wdata_o(arr_wdata_o), .arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o),
        .arr_merase_o(arr_merase_o), .nv_pe_i(nv_pe_i), .nv_re_i(nv_re_i), .nv_commit_o(nv_commit_o),
        .nv_pe_o(nv_pe_o), .nv_re_o(nv_re_o), .irq_o(irq_o));
    flc_flash_model model (.clk_i(clk_i), .arr_addr_i(arr_addr_o), .arr_wdata_i(arr_wdata_o),
        .arr_prog_i(arr_prog_o), .arr_erase_i(arr_erase_o), .arr_merase_i(arr_merase_o),
        .nv_commit_i(nv_commit_o), .nv_pe_i(nv_pe_o), .nv_re_i(nv_re_o), .arr_rdata_o(arr_rdata_i),
        .nv_pe_o(nv_pe_i), .nv_re_o(nv_re_i));
    // ==========================================
    // Shared tasks
    task stop_test;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("unexpected %s exp %h seen %h", nm, e, s);
            err_total++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i); reg_addr_i <= a; reg_wdata_i <= d; reg_we_i <= 1;
        @(posedge clk_i); reg_we_i <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_i); reg_addr_i <= a; reg_re_i <= 1;
        @(posedge clk_i); reg_re_i <= 0;
        #1 chk(nm, reg_rdata_o, e);
    endtask
    // Bounded wait so a stuck operation cannot hang the run
    task op(input logic [31:0] c);
        wr(8'h08, c);
        n = 0;
        #1;
        while ((arr_prog_o | arr_erase_o | arr_merase_o) && n < 30000) begin
            chk("hold", acc_ready_o, 0);
            @(posedge clk_i); #1; n++;
        end
        chk("op_end", n < 30000, 1);
    endtask
    task acc(input logic f, input logic [16:0] a, input logic e, input string nm);
        @(posedge clk_i); acc_valid_i <= 1; acc_fetch_i <= f; acc_addr_i <= a;
        #1 chk(nm, acc_fault_o, e);
        @(posedge clk_i); acc_valid_i <= 0;
    endtask
    task do_reset;
        @(posedge clk_i); reset_i <= 1;
        repeat (2) @(posedge clk_i);
        reset_i <= 0;
    endtask
    // ==========================================
    // Scenarios
    task t_reset;
        rd(8'h1c, 32'h31, "usec");
        rd(8'h20, 32'hffffffff, "pe0");
        rd(8'h24, 32'h0000ffff, "pe1");
        rd(8'h2c, 32'h0000ffff, "re1");
        rd(8'h30, 32'h0, "unmapped");
    endtask
    task t_program;
        wr(8'h1c, 32'h1);
        wr(8'h04, 32'h0000ff0f); wr(8'h00, 32'h804);
        op(32'ha4420001);
        chk("prog_len", (n >= 39 && n <= 42), 1);
        chk("word", model.mem[16'h201], 32'h0000ff0f);
        rd(8'h0c, 32'h2, "done");
        wr(8'h1c, 32'h0); wr(8'h04, 32'hffff00ff);
        op(32'ha4420001);
        chk("word2", model.mem[16'h201], 32'h0000000f);
        wr(8'h18, 32'h2);
        rd(8'h0c, 32'h0, "done_clr");
    endtask
    task t_erase;
        op(32'ha4420002);
        chk("erased", model.mem[16'h201], 32'hffffffff);
        rd(8'h0c, 32'h2, "erase_done");
        wr(8'h18, 32'h2);
        rd(8'h0c, 32'h0, "erase_clr");
    endtask
    task t_protect;
        wr(8'h20, 32'hfffffffd); wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'hfffffffd, "pe0_clr");
        wr(8'h04, 32'h0); wr(8'h00, 32'hc00);
        op(32'ha4420001);
        chk("kept", model.mem[16'h300], 32'hffffffff);
        rd(8'h0c, 32'h1, "viol");
        chk("irq_off", irq_o, 0);
        wr(8'h10, 32'h1);
        #1 chk("irq_on", irq_o, 1);
        wr(8'h18, 32'h1);
        #1 chk("irq_clr", irq_o, 0);
        rd(8'h14, 32'h0, "mstat");
    endtask
    task t_read;
        wr(8'h28, 32'hfffffffd);
        acc(0, 17'h800, 1, "rd_prot");
        acc(1, 17'h800, 0, "fetch");
        acc(0, 17'h7fc, 0, "rd_open");
        acc(0, 17'h18000, 1, "rd_range");
    endtask
    task t_commit;
        wr(8'h08, 32'ha4420008);
        #1 chk("commit", nv_commit_o, 1);
        wr(8'h20, 32'hfffffff9);
        do_reset;
        rd(8'h20, 32'hfffffffd, "pe0_por");
        rd(8'h28, 32'hfffffffd, "re0_nv");
        op(32'ha4420004);
        rd(8'h0c, 32'h1, "merase_ref");
    endtask
    initial begin
        #500000;
        err_total++;
        stop_test;
    end
    initial begin
        do_reset;
        t_reset;
        t_program;
        t_erase;
        t_protect;
        t_read;
        t_commit;
        stop_test;
    end
endmodule
bind flc_ctrl flc_ctrl_assertions u_chk (.clk_i(clk_i), .reset_i(reset_i), .acc_valid_i(acc_valid_i),
    .acc_fetch_i(acc_fetch_i), .acc_addr_i(acc_addr_i), .acc_ready_o(acc_ready_o), .acc_fault_o(acc_fault_o),
    .arr_rdata_i(arr_rdata_i), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o), .arr_prog_o(arr_prog_o),
    .arr_erase_o(arr_erase_o), .arr_merase_o(arr_merase_o), .nv_commit_o(nv_commit_o),
    .nv_pe_o(nv_pe_o), .nv_re_o(nv_re_o));

/* verification/flc_flash_model.sv */
`timescale 1ns/1ps
// ==========================================
// Flash array and protection store
module flc_flash_model (
    input  wire        clk_i,
    input  wire [16:0] arr_addr_i,
    input  wire [31:0] arr_wdata_i,
    input  wire        arr_prog_i,
    input  wire        arr_erase_i,
    input  wire        arr_merase_i,
    input  wire        nv_commit_i,
    input  wire [47:0] nv_pe_i,
    input  wire [47:0] nv_re_i,
    output wire [31:0] arr_rdata_o,
    output reg  [47:0] nv_pe_o,
    output reg  [47:0] nv_re_o
);
    logic [31:0] mem [0:24575];
    logic        erase_q = 1'b0;
    logic        merase_q = 1'b0;
    initial begin
        for (int i = 0; i < 24576; i++) mem[i] = 32'hffffffff;
        nv_pe_o = '1;
        nv_re_o = '1;
    end
    assign arr_rdata_o = (arr_addr_i < 17'h18000) ? mem[arr_addr_i[16:2]] : 32'hffffffff;
    always @(posedge clk_i) begin
        erase_q <= arr_erase_i;
        merase_q <= arr_merase_i;
        if (arr_prog_i) mem[arr_addr_i[16:2]] <= arr_wdata_i;
        if (arr_erase_i && !erase_q)
            for (int i = 0; i < 256; i++) mem[{arr_addr_i[16:10], i[7:0]}] <= 32'hffffffff;
        if (arr_merase_i && !merase_q)
            for (int i = 0; i < 24576; i++) mem[i] <= 32'hffffffff;
        if (nv_commit_i) begin
            nv_pe_o <= nv_pe_i;
            nv_re_o <= nv_re_i;
        end
    end
endmodule
